// File: pkg/rsd_regs.svh
/*
 Register offsets, field positions, reset values and timing
 figures for the reset source and configuration decode block.
 Assumes the includer wants plain macros and no other state.
*/
`ifndef RSD_REGS_SVH
`define RSD_REGS_SVH

// Register byte offsets
`define RSD_OFS_CFG      8'h00
`define RSD_OFS_WDCTL    8'h04
`define RSD_OFS_STATUS   8'h08
`define RSD_OFS_KEEP     8'h0c

// Configuration word fields
`define RSD_CFG_DPROT    7
`define RSD_CFG_PPROT    6
`define RSD_CFG_EXTSEL   5
`define RSD_CFG_PWRTDIS  4
`define RSD_CFG_WDTEN    3
`define RSD_CFG_OSC_HI   2
`define RSD_CFG_OSC_LO   0
`define RSD_CFG_RESET    16'h3fff

// Watchdog control fields
`define RSD_WD_SOFT      0

// Status fields
`define RSD_ST_TO        0
`define RSD_ST_PD        1
`define RSD_ST_CAUSE_LO  4
`define RSD_ST_CAUSE_HI  6
`define RSD_ST_WDT_ON    8
`define RSD_ST_POWERUP_DELAY_TIMER_RUN  9

// Timing figures
`define RSD_POWERUP_DELAY_TIMER_MS      64
`define RSD_LFOSC_KHZ    31
`define RSD_REARM_US     100
`define RSD_CLK_MHZ      250
`define RSD_FILT_CYC     16

`endif

// File: pkg/rsd_pkg.sv
/*
 Types shared by the reset source and configuration decode block.
 Assumes rsd_regs.svh supplies the numeric constants.
*/
package rsd_pkg;

    // Sequencer states
    typedef enum logic [2:0] {
        RSD_ST_POR  = 3'b000,
        RSD_ST_POWERUP_DELAY_TIMER = 3'b001,
        RSD_ST_RUN  = 3'b010,
        RSD_ST_MASTER_CLEAR_PIN = 3'b011,
        RSD_ST_WDT  = 3'b100
    } rsd_state_t;

    // Oscillator modes, codes as held in the config word
    typedef enum logic [2:0] {
        RSD_OSC_RC_CLOCK_OUTPUT_FUNCTION = 3'b111,
        RSD_OSC_RC_IO     = 3'b110,
        RSD_OSC_INT_CLOCK_OUTPUT_FUNCTION= 3'b101,
        RSD_OSC_INT_IO    = 3'b100,
        RSD_OSC_EXT_CLK   = 3'b011,
        RSD_OSC_FAST_XTAL = 3'b010,
        RSD_OSC_XTAL      = 3'b001,
        RSD_OSC_LP_XTAL   = 3'b000
    } rsd_osc_t;

    // Last reset cause
    typedef enum logic [2:0] {
        RSD_CAUSE_NONE      = 3'b000,
        RSD_CAUSE_POR       = 3'b001,
        RSD_CAUSE_WDT_RUN   = 3'b010,
        RSD_CAUSE_WDT_SLEEP = 3'b011,
        RSD_CAUSE_PIN_RUN   = 3'b100,
        RSD_CAUSE_PIN_SLEEP = 3'b101,
        RSD_CAUSE_BOR       = 3'b110
    } rsd_cause_t;

    // Complete state of the block
    typedef struct packed {
        rsd_state_t  st;
        logic [15:0] filt_cnt;
        logic        pin_low;
        logic [15:0] powerup_delay_timer_cnt;
        logic [15:0] gnd_cnt;
        logic        armed;
        rsd_cause_t  cause;
        logic        to;
        logic        pd;
        logic [15:0] cfg;
        logic        soft_wdt;
        logic [15:0] keep;
        logic [15:0] rdata;
        logic        erase_data;
        logic        erase_prog;
    } rsd_st_t;

endpackage

// File: src/rsd_reset_ctrl.sv
/*
 Reset source combiner, power-up delay and configuration decode.
 Assumes: one 250 MHz clock, synchronous pin and detector inputs,
 a one-cycle tick from the slow internal oscillator, and a
 register port with read data one cycle after the read strobe.
*/
// Implementation choices: the register offsets and the strobed register port.
// Functional notes
// - Bit 5 selects pin reset, else held inactive
// - Bit 4 high disables power-up delay
// - Bit 3 or soft bit enables watchdog
// - Decode eight oscillator modes from bits 2:0
// - Oscillator pin roles follow mode code
// - Brown-out and delay enables stay independent
// - Data protection off erases data memory
// - Program protection off erases program memory
// - Pin reset in internal/RC mode stops oscillator
// - Six reset kinds are told apart
// - Some registers keep content across resets
// - Chip resets reload; watchdog wake does not
// - Flags report which reset happened
// - Pin reset path rejects short pulses
// - Watchdog reset never drives the pin
// - Hold reset until supply adequate
// - Power-on re-arms after 100 us at ground
// - Weak pull-up when pin reset selected
// - Serial programming entry unaffected by selection
// - Flag values per reset kind
// - Power-up delay 64 ms from slow oscillator
`include "rsd_regs.svh"

module rsd_reset_ctrl
    import rsd_pkg::*;
#(
    parameter int POWERUP_DELAY_TIMER_TICKS =
        `RSD_POWERUP_DELAY_TIMER_MS * `RSD_LFOSC_KHZ,
    parameter int REARM_CYC  =
        `RSD_REARM_US * `RSD_CLK_MHZ,
    parameter int FILT_CYC   = `RSD_FILT_CYC
) (
    // Clock, reset, enable
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic        ce,
    // Register port
    input  wire logic [7:0]  addr,
    input  wire logic [15:0] wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic      [15:0] rdata,
    // Reset pin and detectors
    input  wire logic        master_clear_pin,
    output logic             master_clear_pin_o,
    output logic             master_clear_pin_oe,
    output logic             pin_pullup_en,
    output logic             pin_digital_in,
    input  wire logic        supply_ok,
    input  wire logic        supply_at_ground,
    input  wire logic        brownout_below,
    input  wire logic        brownout_enable,
    input  wire logic        lfosc_tick,
    // Core events
    input  wire logic        watchdog_timeout,
    input  wire logic        in_sleep,
    input  wire logic        prog_entry_req,
    // Outputs to the chip
    output logic             chip_reset,
    output logic             watchdog_wake,
    output logic             watchdog_enable,
    output logic             powerup_delay_en,
    output rsd_osc_t         osc_mode,
    output logic             osc2_clock_out,
    output logic             osc2_is_io,
    output logic             osc1_is_io,
    output logic             int_osc_stop,
    output logic             data_erase,
    output logic             prog_erase,
    output logic             prog_entry,
    output logic             timeout_flag,
    output logic             powerdown_flag,
    output rsd_cause_t       reset_cause
);

    // Registered state and its next value
    rsd_st_t s_reg;
    rsd_st_t s_next;

    // Decoded pieces used in several places
    logic     ext_sel;       // Pin acts as reset input
    logic     ext_rst;       // Filtered, selected pin reset
    logic     bor_trip;      // Brown-out condition present
    logic     supply_good;   // Supply adequate for release
    logic     rearm_hit;     // Ground held long enough
    logic     wdt_on;        // Effective watchdog enable
    rsd_osc_t mode;          // Oscillator mode code

    // Oscillator mode is internal or RC type
    function automatic logic osc_is_rc_int(rsd_osc_t m);
        return m == RSD_OSC_RC_CLOCK_OUTPUT_FUNCTION || m == RSD_OSC_RC_IO ||
               m == RSD_OSC_INT_CLOCK_OUTPUT_FUNCTION || m == RSD_OSC_INT_IO;
    endfunction

    // Configuration decode
    always_comb begin
        ext_sel  = s_reg.cfg[`RSD_CFG_EXTSEL];
        // Disabled pin function looks like a released pin
        ext_rst  = ext_sel & s_reg.pin_low;
        // Brown-out enable comes from its own mode logic
        bor_trip = brownout_enable & brownout_below;
        supply_good = supply_ok & ~bor_trip;
        rearm_hit = s_reg.gnd_cnt >= 16'(REARM_CYC);
        wdt_on   = s_reg.cfg[`RSD_CFG_WDTEN] | s_reg.soft_wdt;
        mode     = rsd_osc_t'(
            s_reg.cfg[`RSD_CFG_OSC_HI:`RSD_CFG_OSC_LO]);
    end

    // Next state of the whole block
    always_comb begin
        s_next = s_reg;
        s_next.erase_data = 1'b0;
        s_next.erase_prog = 1'b0;

        // Pin filter: must stay at one level to be believed.
        // While the pin is plain input the filter is parked released,
        // so a stale low cannot reset the chip once the pin is selected
        if (!ext_sel) begin
            s_next.pin_low  = 1'b0;
            s_next.filt_cnt = 16'h0000;
        end else if (master_clear_pin == ~s_reg.pin_low) begin
            s_next.filt_cnt = 16'h0000;
        end else if (s_reg.filt_cnt >= 16'(FILT_CYC - 1)) begin
            // Level held long enough, accept it
            s_next.pin_low  = ~master_clear_pin;
            s_next.filt_cnt = 16'h0000;
        end else begin
            s_next.filt_cnt = s_reg.filt_cnt + 16'h0001;
        end

        // Ground timer; a falling supply alone never resets
        if (!supply_at_ground) begin
            s_next.gnd_cnt = 16'h0000;
        end else if (!rearm_hit) begin
            s_next.gnd_cnt = s_reg.gnd_cnt + 16'h0001;
        end
        if (rearm_hit) begin
            s_next.armed = 1'b1;
        end

        // Read data stands only in the cycle after the strobe
        s_next.rdata = 16'h0000;
        if (rd) begin
            unique case (addr)
                `RSD_OFS_CFG: begin
                    s_next.rdata = s_reg.cfg;
                end
                `RSD_OFS_WDCTL: begin
                    s_next.rdata = {15'h0000, s_reg.soft_wdt};
                end
                `RSD_OFS_STATUS: begin
                    s_next.rdata[`RSD_ST_TO] = s_reg.to;
                    s_next.rdata[`RSD_ST_PD] = s_reg.pd;
                    s_next.rdata[`RSD_ST_CAUSE_HI:`RSD_ST_CAUSE_LO] =
                        s_reg.cause;
                    s_next.rdata[`RSD_ST_WDT_ON]   = wdt_on;
                    s_next.rdata[`RSD_ST_POWERUP_DELAY_TIMER_RUN] =
                        s_reg.st == RSD_ST_POWERUP_DELAY_TIMER;
                end
                `RSD_OFS_KEEP: begin
                    s_next.rdata = s_reg.keep;
                end
                default: begin
                    // Unmapped reads return zero
                    s_next.rdata = 16'h0000;
                end
            endcase
        end

        // Register writes
        if (wr) begin
            unique case (addr)
                `RSD_OFS_CFG: begin
                    s_next.cfg = wdata;
                    // Protection going off wipes the memory
                    s_next.erase_data = wdata[`RSD_CFG_DPROT] &
                        ~s_reg.cfg[`RSD_CFG_DPROT];
                    s_next.erase_prog = wdata[`RSD_CFG_PPROT] &
                        ~s_reg.cfg[`RSD_CFG_PPROT];
                end
                `RSD_OFS_WDCTL: begin
                    s_next.soft_wdt = wdata[`RSD_WD_SOFT];
                end
                `RSD_OFS_KEEP: begin
                    s_next.keep = wdata;
                end
                default: begin
                    // Unmapped writes are dropped
                end
            endcase
        end

        // Reset sequencer
        unique case (s_reg.st)
            RSD_ST_POR: begin
                // Held until supply and brown-out allow release
                s_next.powerup_delay_timer_cnt = 16'h0000;
                if (supply_good) begin
                    s_next.armed = 1'b0;
                    if (!s_reg.cfg[`RSD_CFG_PWRTDIS]) begin
                        s_next.st = RSD_ST_POWERUP_DELAY_TIMER;
                    end else begin
                        s_next.st = RSD_ST_MASTER_CLEAR_PIN;
                    end
                end
            end
            RSD_ST_POWERUP_DELAY_TIMER: begin
                // Delay counts slow ticks; brown-out restarts it
                if (bor_trip) begin
                    s_next.st = RSD_ST_POR;
                end else if (s_reg.powerup_delay_timer_cnt >=
                             16'(POWERUP_DELAY_TIMER_TICKS - 1)) begin
                    s_next.st = RSD_ST_MASTER_CLEAR_PIN;
                end else if (lfosc_tick) begin
                    s_next.powerup_delay_timer_cnt = s_reg.powerup_delay_timer_cnt + 16'h0001;
                end
            end
            RSD_ST_MASTER_CLEAR_PIN: begin
                // Pin held low keeps reset after timeouts expire
                if (bor_trip) begin
                    s_next.st = RSD_ST_POR;
                end else if (!ext_rst) begin
                    s_next.st = RSD_ST_RUN;
                end
            end
            RSD_ST_WDT: begin
                // One held cycle for an internal watchdog reset
                s_next.st = RSD_ST_RUN;
            end
            RSD_ST_RUN: begin
                // Priority: power-on, brown-out, pin, watchdog
                if (s_reg.armed && !supply_ok) begin
                    s_next.st    = RSD_ST_POR;
                    s_next.cause = RSD_CAUSE_POR;
                    s_next.to    = 1'b1;
                    s_next.pd    = 1'b1;
                end else if (bor_trip) begin
                    s_next.st    = RSD_ST_POR;
                    s_next.cause = RSD_CAUSE_BOR;
                    s_next.to    = 1'b1;
                    s_next.pd    = 1'b1;
                end else if (ext_rst) begin
                    s_next.st    = RSD_ST_MASTER_CLEAR_PIN;
                    if (in_sleep) begin
                        s_next.cause = RSD_CAUSE_PIN_SLEEP;
                        s_next.to    = 1'b1;
                        s_next.pd    = 1'b0;
                    end else begin
                        // Flags left as they were
                        s_next.cause = RSD_CAUSE_PIN_RUN;
                    end
                end else if (watchdog_timeout && wdt_on) begin
                    s_next.to = 1'b0;
                    if (in_sleep) begin
                        // Wake only: no register reload
                        s_next.cause = RSD_CAUSE_WDT_SLEEP;
                        s_next.pd    = 1'b0;
                    end else begin
                        s_next.st    = RSD_ST_WDT;
                        s_next.cause = RSD_CAUSE_WDT_RUN;
                    end
                end
            end
            default: begin
                s_next.st = RSD_ST_POR;
            end
        endcase

        // Chip resets reload the software control bits
        if (s_next.st != RSD_ST_RUN) begin
            s_next.soft_wdt = 1'b0;
        end
    end

    // State register; the keep word survives even cold reset
    always_ff @(posedge clk) begin
        if (reset) begin
            s_reg          <= '0;
            s_reg.st       <= RSD_ST_POR;
            s_reg.armed    <= 1'b1;
            s_reg.cause    <= RSD_CAUSE_POR;
            s_reg.to       <= 1'b1;
            s_reg.pd       <= 1'b1;
            s_reg.cfg      <= `RSD_CFG_RESET;
            s_reg.keep     <= s_reg.keep;
        end else if (ce) begin
            s_reg <= s_next;
        end
    end

    // Outputs
    always_comb begin
        rdata = s_reg.rdata;
        // Pin is input only; watchdog never pulls it low
        master_clear_pin_o  = 1'b0;
        master_clear_pin_oe = 1'b0;
        pin_pullup_en  = ext_sel;
        pin_digital_in = ext_sel ? 1'b1 : master_clear_pin;
        // Assert at once on brown-out or pin reset, release by the
        // registered state so all registers leave together
        chip_reset = reset || s_reg.st != RSD_ST_RUN ||
                     bor_trip || ext_rst;
        watchdog_wake = s_reg.cause == RSD_CAUSE_WDT_SLEEP &&
                        !s_reg.pd && !s_reg.to;
        watchdog_enable  = wdt_on;
        powerup_delay_en = ~s_reg.cfg[`RSD_CFG_PWRTDIS];
        osc_mode       = mode;
        osc2_clock_out = mode == RSD_OSC_RC_CLOCK_OUTPUT_FUNCTION ||
                         mode == RSD_OSC_INT_CLOCK_OUTPUT_FUNCTION;
        osc2_is_io     = mode == RSD_OSC_RC_IO ||
                         mode == RSD_OSC_INT_IO ||
                         mode == RSD_OSC_EXT_CLK;
        osc1_is_io     = mode == RSD_OSC_INT_CLOCK_OUTPUT_FUNCTION ||
                         mode == RSD_OSC_INT_IO;
        int_osc_stop   = ext_rst & osc_is_rc_int(mode);
        data_erase     = s_reg.erase_data;
        prog_erase     = s_reg.erase_prog;
        // Programming entry bypasses the pin selection
        prog_entry     = prog_entry_req;
        timeout_flag   = s_reg.to;
        powerdown_flag = s_reg.pd;
        reset_cause    = s_reg.cause;
    end

endmodule

// File: dv/rsd_sva.sv
/*
 Checker for rsd_reset_ctrl, bound to its ports.
 Assumes ce is held high and the pin and detectors are synchronous.
*/
module rsd_sva
    import rsd_pkg::*;
#(
    parameter int FILT_CYC = 16
) (
    // Clock and reset
    input logic        clk,
    input logic        reset,
    // Register writes
    input logic [7:0]  addr,
    input logic [15:0] wdata,
    input logic        wr,
    // Pin and detectors
    input logic        master_clear_pin,
    input logic        master_clear_pin_o,
    input logic        master_clear_pin_oe,
    input logic        pin_pullup_en,
    input logic        pin_digital_in,
    input logic        supply_ok,
    input logic        brownout_below,
    input logic        brownout_enable,
    // Core events
    input logic        watchdog_timeout,
    input logic        in_sleep,
    input logic        prog_entry_req,
    // Outputs under watch
    input logic        chip_reset,
    input logic        watchdog_wake,
    input logic        watchdog_enable,
    input rsd_osc_t    osc_mode,
    input logic        osc2_clock_out,
    input logic        osc2_is_io,
    input logic        osc1_is_io,
    input logic        int_osc_stop,
    input logic        data_erase,
    input logic        prog_erase,
    input logic        prog_entry,
    input logic        timeout_flag,
    input logic        powerdown_flag
);
    timeunit 1ns;
    timeprecision 1ps;

    // Consecutive low samples of the pin; saturates so it never wraps back under the filter
    logic [7:0] low_cnt;

    always_ff @(posedge clk) begin
        if (reset || master_clear_pin) begin
            low_cnt <= 8'h00;
        end else if (low_cnt != 8'hff) begin
            low_cnt <= low_cnt + 8'h01;
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (reset);

    // Watchdog expiry while running, enabled, and no stronger source pending
    sequence s_wdt_hit;
        !chip_reset && watchdog_enable && watchdog_timeout && master_clear_pin && supply_ok
            && !(brownout_enable && brownout_below);
    endsequence

    // One reset cycle, then running again with the timeout flag cleared
    sequence s_wdt_pulse;
        chip_reset ##1 (!chip_reset && !timeout_flag);
    endsequence

    a_wdt_run_pulse: assert property (s_wdt_hit ##0 !in_sleep |=> s_wdt_pulse)
        else $error("watchdog reset in run is wrong");
    a_wdt_sleep_wake: assert property (s_wdt_hit ##0 in_sleep |=> !chip_reset && !timeout_flag && !powerdown_flag && watchdog_wake)
        else $error("watchdog wake from sleep is wrong");
    a_pin_filter_pass: assert property (pin_pullup_en && low_cnt > FILT_CYC |-> chip_reset)
        else $error("held pin low did not reset");
    a_pin_never_driven: assert property (!master_clear_pin_oe && !master_clear_pin_o)
        else $error("reset pin driven");
    a_pin_select_in: assert property (pin_digital_in == (pin_pullup_en ? 1'b1 : master_clear_pin))
        else $error("pin digital input wrong");
    a_osc_pin_roles: assert property ((osc2_clock_out == (osc_mode inside {3'b111, 3'b101}))
        && (osc2_is_io == (osc_mode inside {3'b110, 3'b100, 3'b011}))
        && (osc1_is_io == (osc_mode[2:1] == 2'b10)))
        else $error("oscillator pin roles wrong");
    a_osc_stop_cause: assert property (int_osc_stop |-> chip_reset && osc_mode[2])
        else $error("oscillator stopped without cause");
    a_bor_holds_reset: assert property (brownout_enable && brownout_below |-> ##[0:2] chip_reset)
        else $error("brown-out did not reset");
    a_data_erase_src: assert property (data_erase |-> $past(wr) && $past(addr) == 8'h00 && $past(wdata[7]))
        else $error("data erase without unprotect");
    a_prog_erase_src: assert property (prog_erase |-> $past(wr) && $past(addr) == 8'h00 && $past(wdata[6]))
        else $error("program erase without unprotect");
    a_prog_entry_pass: assert property (prog_entry == prog_entry_req)
        else $error("programming entry altered");
endmodule

bind rsd_reset_ctrl rsd_sva #(.FILT_CYC(FILT_CYC)) u_sva (.*);

// File: dv/rsd_partner.sv
/*
 Far side of the reset block: reset pin with its pull-up,
 supply and brown-out detectors, and the slow oscillator tick.
 Assumes the bench moves its commands at rising clock edges.
*/
module rsd_partner (
    // Clock and bench commands
    input  logic clk,
    input  logic drive_low,
    input  logic sup_on,
    input  logic gnd,
    input  logic bor,
    input  logic pin_pullup_en,
    // Lines into the block
    output logic master_clear_pin,
    output logic supply_ok,
    output logic supply_at_ground,
    output logic brownout_below,
    output logic lfosc_tick
);
    timeunit 1ns;
    timeprecision 1ps;

    logic       flt = 1'b0;  // An unheld pin wanders, so a stale level is never trusted
    logic [1:0] div = 2'b00; // Slow tick divider, shortened to keep the run brief

    // Advance the wander pattern and the divider
    always @(posedge clk) begin
        flt <= ~flt;
        div <= div + 2'b01;
    end

    // Button wins, else the weak pull-up, else the pin floats
    assign master_clear_pin = drive_low ? 1'b0 : (pin_pullup_en ? 1'b1 : flt);
    assign supply_ok        = sup_on;
    assign supply_at_ground = gnd & ~sup_on;
    assign brownout_below   = bor | ~sup_on;  // A dead supply is also below threshold
    assign lfosc_tick       = (div == 2'b11);
endmodule

// File: dv/testbench.sv
/*
 Self-checking bench for rsd_reset_ctrl with the far-side model.
 Assumes the block's register port answers reads one cycle later.
*/
module testbench
    import rsd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int FILT  = 2;  // Shortened pin filter
    localparam int POWERUP_DELAY_TIMER  = 4;  // Shortened power-up delay, in ticks
    localparam int REARM = 8;  // Shortened ground time
    int fails = 0;
    int tests_run = 0;
    int cyc = 0;
    logic [15:0] v;
    // Bench-driven inputs and far-side commands
    logic clk = 1'b0, reset = 1'b1, ce = 1'b1, wr = 1'b0, rd = 1'b0, in_sleep = 1'b0;
    logic watchdog_timeout = 1'b0, prog_entry_req = 1'b0, brownout_enable = 1'b0;
    logic drive_low = 1'b0, sup_on = 1'b1, gnd = 1'b0, bor = 1'b0;
    logic [7:0]  addr = 8'h00;
    logic [15:0] wdata = 16'h0000, rdata;
    // Block outputs and far-side lines
    logic master_clear_pin, master_clear_pin_o, master_clear_pin_oe, pin_pullup_en, pin_digital_in;
    logic supply_ok, supply_at_ground, brownout_below, lfosc_tick, chip_reset, watchdog_wake;
    logic watchdog_enable, powerup_delay_en, osc2_clock_out, osc2_is_io, osc1_is_io, int_osc_stop;
    logic data_erase, prog_erase, prog_entry, timeout_flag, powerdown_flag;
    rsd_osc_t   osc_mode;
    rsd_cause_t reset_cause;

    `define CHK(n, e, a) begin tests_run++; if ((a) !== (e)) begin fails++; \
        $display("MISMATCH %s expected %0h seen %0h", n, e, a); end end

    always #2 clk = ~clk;

    rsd_reset_ctrl #(.POWERUP_DELAY_TIMER_TICKS(POWERUP_DELAY_TIMER), .REARM_CYC(REARM), .FILT_CYC(FILT)) DUT (.*);
    rsd_partner u_far (.*);

    // Write one register
    task automatic wreg(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask

    // Read one register; data stand only in the cycle after the strobe
    task automatic rreg(input logic [7:0] a, output logic [15:0] d);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask

    // Status flags and cause
    task automatic chk_st(input logic [2:0] c, input logic t, input logic p);
        rreg(8'h08, v);
        `CHK("status", {9'h000, c, 2'b00, p, t}, v & 16'h0073)
        `CHK("cause", c, reset_cause)
    endtask

    // Bounded wait for the chip to run
    task automatic wait_run();
        int n;
        n = 0;
        while (chip_reset !== 1'b0 && n < 200) begin
            @(posedge clk);
            #1;
            n++;
        end
        `CHK("run", 1'b0, chip_reset)
    endtask

    // Hold the pin low n cycles, release it, then judge reset just after the release
    task automatic pin_low(input int n, input logic e);
        @(posedge clk);
        drive_low <= 1'b1;
        repeat (n) @(posedge clk);
        drive_low <= 1'b0;
        #1;
        `CHK("pin reset", e, chip_reset)
        `CHK("osc stop", e, int_osc_stop)
    endtask

    // One watchdog expiry pulse
    task automatic wdt_pulse();
        @(posedge clk);
        watchdog_timeout <= 1'b1;
        @(posedge clk);
        watchdog_timeout <= 1'b0;
        #1;
    endtask

    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            fails++;
            conclude();
        end
    end

    // Main sequence
    initial begin
        repeat (12) @(posedge clk);
        `CHK("cold", 1'b1, chip_reset)
        reset <= 1'b0;
        wait_run();
        rreg(8'h00, v);
        `CHK("cfg", 16'h3fff, v)
        chk_st(3'd1, 1'b1, 1'b1);
        rreg(8'h10, v);
        `CHK("unmapped", 16'h0000, v)
        wreg(8'h0c, 16'h5a3c);
        for (int m = 0; m < 8; m++) begin
            wreg(8'h00, 16'h3ff8 | 16'(m));
            `CHK("osc mode", 3'(m), osc_mode)
            `CHK("osc2 clk", (m == 7 || m == 5), osc2_clock_out)
            `CHK("osc2 io", (m == 6 || m == 4 || m == 3), osc2_is_io)
            `CHK("osc1 io", (m == 5 || m == 4), osc1_is_io)
        end
        // Internal reset option: pin is plain input, pulling it low does nothing
        wreg(8'h00, 16'h3fdf);
        `CHK("pullup off", 1'b0, pin_pullup_en)
        pin_low(6, 1'b0);
        wreg(8'h00, 16'h3fff);
        `CHK("pullup on", 1'b1, pin_pullup_en)
        pin_low(FILT - 1, 1'b0);
        pin_low(6, 1'b1);
        wait_run();
        chk_st(3'd4, 1'b1, 1'b1);
        // Soft watchdog enable, then a watchdog reset in run
        wreg(8'h00, 16'h3ff7);
        `CHK("wdt off", 1'b0, watchdog_enable)
        wreg(8'h04, 16'h0001);
        `CHK("wdt soft", 1'b1, watchdog_enable)
        wdt_pulse();
        wait_run();
        chk_st(3'd2, 1'b0, 1'b1);
        rreg(8'h04, v);
        `CHK("soft cleared", 16'h0000, v & 16'h0001)
        // Watchdog wake and pin reset while asleep
        wreg(8'h00, 16'h3fff);
        @(posedge clk) in_sleep <= 1'b1;
        wdt_pulse();
        `CHK("no reset", 1'b0, chip_reset)
        `CHK("wake", 1'b1, watchdog_wake)
        chk_st(3'd3, 1'b0, 1'b0);
        pin_low(6, 1'b1);
        wait_run();
        chk_st(3'd5, 1'b1, 1'b0);
        @(posedge clk) in_sleep <= 1'b0;
        // Unprotecting both memories erases them
        wreg(8'h00, 16'h3f3f);
        wreg(8'h00, 16'h3fff);
        `CHK("data erase", 1'b1, data_erase)
        `CHK("prog erase", 1'b1, prog_erase)
        // Brown-out with the power-up delay enabled
        @(posedge clk) brownout_enable <= 1'b1;
        #1;
        `CHK("delay off", 1'b0, powerup_delay_en)
        wreg(8'h00, 16'h3fef);
        `CHK("delay on", 1'b1, powerup_delay_en)
        @(posedge clk) bor <= 1'b1;
        repeat (3) @(posedge clk);
        bor <= 1'b0;
        repeat (8) @(posedge clk);
        #1;
        `CHK("delay hold", 1'b1, chip_reset)
        wait_run();
        chk_st(3'd6, 1'b1, 1'b1);
        @(posedge clk) brownout_enable <= 1'b0;
        // Supply dip is ignored until ground re-arms power-on detection
        @(posedge clk) sup_on <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
        `CHK("dip", 1'b0, chip_reset)
        @(posedge clk) gnd <= 1'b1;
        repeat (REARM + 2) @(posedge clk);
        gnd <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        `CHK("por", 1'b1, chip_reset)
        @(posedge clk) sup_on <= 1'b1;
        wait_run();
        chk_st(3'd1, 1'b1, 1'b1);
        rreg(8'h0c, v);
        `CHK("keep", 16'h5a3c, v)
        @(posedge clk) prog_entry_req <= 1'b1;
        @(posedge clk) prog_entry_req <= 1'b0;
        @(posedge clk);
        conclude();
    end
endmodule
